// File: ptw_pkg.sv
// Shared constants and carriers for the table walk helper and its pointer cache.
// Assumes a 32-bit table entry, 36-bit physical bus and 32-bit virtual address.
package ptw_pkg;

  // Entry type field and entry bit positions
  localparam logic [1:0] ET_INVALID  = 2'h0;
  localparam logic [1:0] ET_POINTER  = 2'h1;
  localparam logic [1:0] ET_PAGE     = 2'h2;
  localparam logic [1:0] ET_RESERVED = 2'h3;
  localparam int         ET_LSB      = 0;
  localparam int         ACC_LSB     = 2;
  localparam int         REF_BIT     = 5;
  localparam int         MOD_BIT     = 6;
  localparam int         CACHE_BIT   = 7;

  // Virtual address index fields
  localparam int IDX1_LSB = 24;
  localparam int IDX2_LSB = 18;
  localparam int IDX3_LSB = 12;

  // Register byte offsets, field positions and reset values
  localparam logic [3:0]  REG_CTX_NUM  = 4'h0;
  localparam logic [3:0]  REG_CTX_BASE = 4'h4;
  localparam logic [3:0]  REG_STATUS   = 4'h8;
  localparam int          CTX_BASE_LSB = 10;
  localparam logic [11:0] CTX_NUM_RST  = 12'h000;
  localparam logic [21:0] CTX_BASE_RST = 22'h000000;

  // Region sizes as log2 of bytes
  localparam logic [5:0] REGION_CTX = 6'h20;
  localparam logic [5:0] REGION_L1  = 6'h18;
  localparam logic [5:0] REGION_L2  = 6'h12;
  localparam logic [5:0] REGION_L3  = 6'h0c;

  typedef enum logic [1:0] {
    LVL_CTX = 2'b00,
    LVL_1   = 2'b01,
    LVL_2   = 2'b10,
    LVL_3   = 2'b11
  } level_e;

  typedef struct packed {
    level_e      level;
    logic [31:0] data;
    logic [31:0] va;
    logic        instr;
    logic        write_access;
    logic        bus_error;
  } fetch_s;

  typedef struct packed {
    logic [35:0] next_addr;
    logic [35:0] phys_addr;
    logic [1:0]  etype;
    logic        fault_invalid;
    logic        fault_translation;
    logic        found_page;
    logic        cacheable;
    logic [5:0]  region_log2;
    logic        writeback;
    logic [31:0] writeback_entry;
  } walk_result_s;

  typedef struct packed {
    logic        l2_hit;
    logic        root_hit;
    logic [35:0] start_addr;
    level_e      start_level;
  } lookup_s;

endpackage : ptw_pkg

// File: ptr_store.sv
// Four-word store for the level-2 table pointers of the pointer cache.
// Read data are registered; one write and one read per cycle.
`timescale 1ns/10ps
module ptr_store
(
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [27:0] wdata,
  // Read port
  input  wire logic [1:0]  raddr,
  output logic      [27:0] rdata
);

  logic [27:0] mem [4];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : ptr_store

// File: ptw_helper.sv
// Table entry decode, walk address forming, R/M update and pointer cache.
// Assumes an outside sequencer issues lookups on a miss and feeds each fetched
// entry back with its level; it owns the bus cycles and the TLB itself.
`timescale 1ns/10ps

// How it works
// - root pointer 31..6 plus index 1 addresses level 1
// - entry addresses always end in two zero bits
// - level 1/2 pointer 31..4 plus next index
// - type 0 invalid, 1 pointer, 2 page, 3 reserved
// - type 0 raises invalid error, ends walk
// - type 3 raises translation error
// - region size follows level of page entry
// - context page entry 31..28 gives address 35..32
// - unused page bits ignored, virtual bits fill rest
// - page entry read sets referenced bit
// - write-type access sets modified bit if clear
// - cacheable only when entry cacheable bit set
// - five slots, tag slot n serves pair n
// - root stays valid until context registers change
// - tag match reuses level-2 pointer for level 3
// - LRU picks slot to overwrite per access type
// - slots fill only on tag miss reaching level 3
// - walks ending above level 3 cache no level-2 pointer
// - context change drops all five slots
// - reset or base write clears all valid bits
// - TLB invalidate drops level-2 pointer slots
// - probe, flush, block walks also fill cache
// - index fields are va 31..24, 23..18, 17..12
// - level-3 pointer, bus error, reserved: translation error
module ptw_helper
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register bus
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Miss lookup
  input  wire logic                  lookup_valid,
  input  wire logic [31:0]           lookup_va,
  input  wire logic                  lookup_instr,
  output logic                       lookup_done,
  output ptw_pkg::lookup_s           lookup_result,
  // Fetched entries
  input  wire logic                  fetch_valid,
  input  wire ptw_pkg::fetch_s       fetch,
  output logic                       result_valid,
  output ptw_pkg::walk_result_s      result,
  // TLB invalidate
  input  wire logic                  tlb_invalidate
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [13:0] tag_of(input logic [31:0] va);
    tag_of = va[31:ptw_pkg::IDX2_LSB];
  endfunction : tag_of

  // Next entry address from a pointer found at the given level
  function automatic logic [35:0] next_from(input ptw_pkg::level_e lvl,
                                            input logic [31:0] ptr,
                                            input logic [31:0] va);
    unique case (lvl)
      ptw_pkg::LVL_CTX: next_from = {ptr[31:6], va[31:ptw_pkg::IDX1_LSB], 2'b00};
      ptw_pkg::LVL_1:   next_from = {ptr[31:4], va[23:ptw_pkg::IDX2_LSB], 2'b00};
      ptw_pkg::LVL_2:   next_from = {ptr[31:4], va[17:ptw_pkg::IDX3_LSB], 2'b00};
      ptw_pkg::LVL_3:   next_from = 36'h0;
    endcase
  endfunction : next_from

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave

  logic [11:0] context_number_register;
  logic [21:0] context_table_base_register;
  logic        ctx_num_wr;
  logic        ctx_base_wr;
  logic [31:0] status_word;

  // Write takes effect on the edge where waitrequest is seen low
  assign ctx_num_wr  = avs_write && !avs_waitrequest && avs_address == ptw_pkg::REG_CTX_NUM;
  assign ctx_base_wr = avs_write && !avs_waitrequest && avs_address == ptw_pkg::REG_CTX_BASE;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0;
    end
    else if (avs_read && avs_waitrequest)
    begin
      unique case (avs_address)
        ptw_pkg::REG_CTX_NUM:  avs_readdata <= {20'h0, context_number_register};
        ptw_pkg::REG_CTX_BASE: avs_readdata <= {context_table_base_register, 10'h0};
        ptw_pkg::REG_STATUS:   avs_readdata <= status_word;
        default:               avs_readdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      context_number_register     <= ptw_pkg::CTX_NUM_RST;
      context_table_base_register <= ptw_pkg::CTX_BASE_RST;
    end
    else
    begin
      if (ctx_num_wr)
      begin
        context_number_register <= avs_writedata[11:0];
      end
      if (ctx_base_wr)
      begin
        context_table_base_register <= avs_writedata[31:ptw_pkg::CTX_BASE_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer cache state

  logic [25:0] root_pointer_slot;
  logic        root_valid;
  logic [13:0] instr_index_tag [2];
  logic [13:0] data_index_tag [2];
  logic [1:0]  instr_valid;
  logic [1:0]  data_valid;
  logic        instr_lru;
  logic        data_lru;
  logic        drop_all;
  logic        drop_l2;

  assign drop_all = rst || ctx_num_wr || ctx_base_wr;
  assign drop_l2  = drop_all || tlb_invalidate;

  assign status_word = {25'h0, data_lru, instr_lru, data_valid, instr_valid, root_valid};

  // Pending level-2 pointer, held until the walk reaches level 3
  logic        pend_valid;
  logic [27:0] pend_ptr;
  logic [13:0] pend_tag;
  logic        pend_instr;
  logic        commit;
  logic [1:0]  commit_addr;

  assign commit = fetch_valid && pend_valid && fetch.level == ptw_pkg::LVL_3
                  && !drop_l2;
  assign commit_addr = {pend_instr, pend_instr ? instr_lru : data_lru};

  ////////////////////////////////////////////////////////////////////////////
  // Lookup, stage 1: tag compare and pointer read

  logic [1:0]  tag_hit;
  logic        hit_any;
  logic        hit_slot;
  logic [13:0] look_tag;
  logic        s1_valid;
  logic        s1_l2_hit;
  logic [31:0] s1_va;
  logic [27:0] l2_rdata;

  assign look_tag = tag_of(lookup_va);

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_cmp
      // Tag slot i of the looked-up access type serves only that type's pointer at slot i
      assign tag_hit[i] = lookup_instr
                          ? instr_valid[i] && instr_index_tag[i] == look_tag
                          : data_valid[i] && data_index_tag[i] == look_tag;
    end
  endgenerate

  assign hit_any  = |tag_hit;
  assign hit_slot = tag_hit[1];

  ptr_store u_ptr_store
  (
    .clk   (clk),
    .we    (commit),
    .waddr (commit_addr),
    .wdata (pend_ptr),
    .raddr ({lookup_instr, hit_slot}),
    .rdata (l2_rdata)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_valid  <= 1'b0;
      s1_l2_hit <= 1'b0;
      s1_va     <= 32'h0;
    end
    else
    begin
      s1_valid  <= lookup_valid;
      s1_l2_hit <= lookup_valid && hit_any && !drop_l2;
      s1_va     <= lookup_va;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lookup, stage 2: starting point of the walk

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lookup_done   <= 1'b0;
      lookup_result <= '0;
    end
    else
    begin
      lookup_done <= s1_valid;
      lookup_result.l2_hit   <= s1_l2_hit;
      lookup_result.root_hit <= root_valid;
      if (s1_l2_hit)
      begin
        lookup_result.start_addr  <= {l2_rdata, s1_va[17:ptw_pkg::IDX3_LSB], 2'b00};
        lookup_result.start_level <= ptw_pkg::LVL_3;
      end
      else if (root_valid)
      begin
        lookup_result.start_addr  <= {root_pointer_slot, s1_va[31:ptw_pkg::IDX1_LSB], 2'b00};
        lookup_result.start_level <= ptw_pkg::LVL_1;
      end
      else
      begin
        lookup_result.start_addr  <= {context_table_base_register,
                                      context_number_register, 2'b00};
        lookup_result.start_level <= ptw_pkg::LVL_CTX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Root slot

  // Invalidation wins over a fill in the same cycle: that pointer is stale
  always_ff @(posedge clk)
  begin
    if (drop_all)
    begin
      root_valid        <= 1'b0;
    end
    else if (fetch_valid && !fetch.bus_error && fetch.level == ptw_pkg::LVL_CTX
             && fetch.data[1:0] == ptw_pkg::ET_POINTER)
    begin
      root_valid        <= 1'b1;
      root_pointer_slot <= fetch.data[31:6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending level-2 pointer

  always_ff @(posedge clk)
  begin
    if (drop_l2)
    begin
      pend_valid <= 1'b0;
    end
    else if (fetch_valid)
    begin
      // Only a level-2 pointer is a candidate; any other entry ends it
      pend_valid <= !fetch.bus_error && fetch.level == ptw_pkg::LVL_2
                    && fetch.data[1:0] == ptw_pkg::ET_POINTER;
      pend_ptr   <= fetch.data[31:4];
      pend_tag   <= tag_of(fetch.va);
      pend_instr <= fetch.instr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level-2 tags, valid bits and LRU

  always_ff @(posedge clk)
  begin
    if (drop_l2)
    begin
      instr_valid <= 2'b00;
      data_valid  <= 2'b00;
    end
    else if (commit && pend_instr)
    begin
      instr_valid[instr_lru]     <= 1'b1;
      instr_index_tag[instr_lru] <= pend_tag;
    end
    else if (commit)
    begin
      data_valid[data_lru]     <= 1'b1;
      data_index_tag[data_lru] <= pend_tag;
    end
  end

  // LRU points at the slot to replace next
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      instr_lru <= 1'b0;
      data_lru  <= 1'b0;
    end
    else if (commit)
    begin
      if (pend_instr)
      begin
        instr_lru <= !instr_lru;
      end
      else
      begin
        data_lru <= !data_lru;
      end
    end
    else if (lookup_valid && hit_any)
    begin
      if (lookup_instr)
      begin
        instr_lru <= !hit_slot;
      end
      else
      begin
        data_lru <= !hit_slot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry decode and physical address

  logic [1:0]  etype;
  logic        is_page;
  logic        bad_invalid;
  logic        bad_trans;
  logic [35:0] pa;
  logic [5:0]  region;
  logic [31:0] upd_entry;

  assign etype   = fetch.data[ptw_pkg::ET_LSB +: 2];
  assign is_page = etype == ptw_pkg::ET_PAGE;

  always_comb
  begin
    bad_invalid = 1'b0;
    bad_trans   = 1'b0;
    if (fetch.bus_error)
    begin
      bad_trans = 1'b1;
    end
    else
    begin
      unique case (etype)
        ptw_pkg::ET_INVALID:  bad_invalid = 1'b1;
        ptw_pkg::ET_POINTER:  bad_trans   = fetch.level == ptw_pkg::LVL_3;
        ptw_pkg::ET_PAGE:     bad_trans   = 1'b0;
        ptw_pkg::ET_RESERVED: bad_trans   = 1'b1;
      endcase
    end
  end

  // Page number bits beyond the region are ignored; virtual bits fill in
  always_comb
  begin
    unique case (fetch.level)
      ptw_pkg::LVL_CTX:
      begin
        pa     = {fetch.data[31:28], fetch.va};
        region = ptw_pkg::REGION_CTX;
      end
      ptw_pkg::LVL_1:
      begin
        pa     = {fetch.data[31:20], fetch.va[23:0]};
        region = ptw_pkg::REGION_L1;
      end
      ptw_pkg::LVL_2:
      begin
        pa     = {fetch.data[31:14], fetch.va[17:0]};
        region = ptw_pkg::REGION_L2;
      end
      ptw_pkg::LVL_3:
      begin
        pa     = {fetch.data[31:8], fetch.va[11:0]};
        region = ptw_pkg::REGION_L3;
      end
    endcase
  end

  always_comb
  begin
    upd_entry = fetch.data;
    upd_entry[ptw_pkg::REF_BIT] = 1'b1;
    if (fetch.write_access)
    begin
      upd_entry[ptw_pkg::MOD_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_valid <= 1'b0;
      result       <= '0;
    end
    else
    begin
      result_valid <= fetch_valid;
      if (fetch_valid)
      begin
        result.etype             <= etype;
        result.fault_invalid     <= bad_invalid;
        result.fault_translation <= bad_trans;
        result.found_page        <= is_page && !bad_trans;
        result.next_addr         <= (bad_invalid || bad_trans || is_page)
                                    ? 36'h0 : next_from(fetch.level, fetch.data, fetch.va);
        result.phys_addr         <= is_page ? pa : 36'h0;
        result.region_log2       <= is_page ? region : 6'h0;
        result.cacheable         <= is_page && fetch.data[ptw_pkg::CACHE_BIT];
        result.writeback         <= is_page && !fetch.bus_error
                                    && upd_entry != fetch.data;
        result.writeback_entry   <= upd_entry;
      end
    end
  end

endmodule : ptw_helper

// File: table_mem_model.sv
// Table memory and fetch sequencer standing in front of the walk helper.
// Assumes the bench preloads mem and pulses req for one cycle per fetch.
`timescale 1ns/10ps
module table_mem_model
(
  // Clock
  input  wire logic            clk,
  // Request from the bench
  input  wire logic            req,
  input  wire logic [35:0]     req_addr,
  input  wire ptw_pkg::fetch_s req_info,
  input  wire logic [3:0]      lag,
  // Entry delivery
  output logic                 fetch_valid,
  output ptw_pkg::fetch_s      fetch
);
  logic [31:0]     mem [bit [35:0]];
  ptw_pkg::fetch_s held;
  logic [35:0]     addr;
  logic [3:0]      cnt;
  logic            pend;

  initial
  begin
    fetch_valid = 1'b0;
    fetch       = '0;
    pend        = 1'b0;
  end

  ////////////////////////////////////////
  // Data lines toggle between deliveries so a stale word never looks valid
  always @(posedge clk)
  begin
    fetch_valid <= 1'b0;
    fetch.data  <= ~fetch.data;
    if (req)
    begin
      held <= req_info;
      addr <= req_addr;
      cnt  <= lag;
      pend <= 1'b1;
    end
    else if (pend && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (pend)
    begin
      pend        <= 1'b0;
      fetch_valid <= 1'b1;
      fetch       <= held;
      // Unmapped words read as invalid entries
      fetch.data  <= mem.exists(addr) ? mem[addr] : 32'h0;
    end
  end
endmodule : table_mem_model

// File: ptw_helper_properties.sv
// Concurrent checks on the walk helper ports.
// Assumes one clock domain and a bind onto every ptw_helper instance.
`timescale 1ns/10ps
module ptw_helper_properties
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register bus
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic                  avs_waitrequest,
  // Lookup and fetch
  input  wire logic                  lookup_valid,
  input  wire logic                  lookup_done,
  input  wire logic                  fetch_valid,
  input  wire ptw_pkg::fetch_s       fetch,
  input  wire logic                  result_valid,
  input  wire ptw_pkg::walk_result_s result
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  ptw_pkg::fetch_s f_q;
  logic            ok_q, pg_q, pt_q;

  always_ff @(posedge clk)
    f_q <= fetch;
  assign ok_q = result_valid && !f_q.bus_error;
  assign pg_q = ok_q && f_q.data[1:0] == ptw_pkg::ET_PAGE;
  assign pt_q = ok_q && f_q.data[1:0] == ptw_pkg::ET_POINTER;

  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_wait_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  ////////////////////////////////////////
  bus_wait_a: assert property (bus_req_s |=> one_wait_s)
    else $error("bus wait state wrong");
  lookup_lat_a: assert property (lookup_done == $past(lookup_valid, 2))
    else $error("lookup latency wrong");
  fetch_lat_a: assert property (result_valid == $past(fetch_valid))
    else $error("result latency wrong");
  word_align_a: assert property (result_valid |-> result.next_addr[1:0] == 2'b00)
    else $error("entry address not word aligned");
  type_decode_a: assert property (ok_q |-> result.etype == f_q.data[1:0])
    else $error("entry type wrongly decoded");
  invalid_stop_a: assert property (ok_q && f_q.data[1:0] == ptw_pkg::ET_INVALID
    |-> result.fault_invalid && !result.found_page && result.next_addr == 36'h0)
    else $error("invalid entry did not stop walk");
  trans_err_a: assert property (result_valid && (f_q.bus_error
    || f_q.data[1:0] == ptw_pkg::ET_RESERVED || (pt_q && f_q.level == ptw_pkg::LVL_3))
    |-> result.fault_translation && !result.found_page)
    else $error("translation error missing");
  root_addr_a: assert property (pt_q && f_q.level == ptw_pkg::LVL_CTX
    |-> result.next_addr == {f_q.data[31:6], f_q.va[31:24], 2'b00})
    else $error("level one address wrong");
  ptr_addr_a: assert property (pt_q && f_q.level inside {ptw_pkg::LVL_1, ptw_pkg::LVL_2}
    |-> result.next_addr == {f_q.data[31:4], f_q.level == ptw_pkg::LVL_1 ?
    f_q.va[23:18] : f_q.va[17:12], 2'b00})
    else $error("next table address wrong");
  ctx_page_a: assert property (pg_q && f_q.level == ptw_pkg::LVL_CTX
    |-> result.phys_addr == {f_q.data[31:28], f_q.va})
    else $error("context page address wrong");
  l3_page_a: assert property (pg_q && f_q.level == ptw_pkg::LVL_3
    |-> result.phys_addr == {f_q.data[31:8], f_q.va[11:0]})
    else $error("level three page address wrong");
  ref_mod_a: assert property (pg_q |-> result.writeback_entry[ptw_pkg::REF_BIT]
    && result.writeback_entry[ptw_pkg::MOD_BIT] == (f_q.data[6] || f_q.write_access))
    else $error("referenced or modified bit wrong");
  cache_bit_a: assert property (pg_q |-> result.cacheable == f_q.data[ptw_pkg::CACHE_BIT])
    else $error("cacheable flag wrong");
  region_a: assert property (pg_q |-> result.region_log2 == (f_q.level == ptw_pkg::LVL_CTX ?
    ptw_pkg::REGION_CTX : f_q.level == ptw_pkg::LVL_1 ? ptw_pkg::REGION_L1 :
    f_q.level == ptw_pkg::LVL_2 ? ptw_pkg::REGION_L2 : ptw_pkg::REGION_L3))
    else $error("region size wrong");
endmodule : ptw_helper_properties

bind ptw_helper ptw_helper_properties chk_u (.*);

// File: page_table_pointer_cache_walk_tb.sv
// Self-checking bench for the walk helper and its pointer cache.
// Assumes the table memory model answers fetches at the requested address.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t got %0h expected %0h", $time, (g), (e)); end end
module page_table_pointer_cache_walk_tb;
  localparam logic [31:0] BW = 32'h1234_5400, CW = 32'h0000_00a5;
  localparam logic [31:0] V1 = 32'h5a6c_3123, V2 = 32'h5a80_0abc, RT = 32'h0abc_de41;
  localparam logic [31:0] P1 = 32'h0111_2231, P2 = 32'h0222_3351;
  localparam logic [31:0] PG = 32'h0333_4482, PG2 = 32'h0444_5502;
  localparam logic [35:0] A0 = {BW[31:10], CW[11:0], 2'b00}, A1 = {RT[31:6], V1[31:24], 2'b00};
  localparam logic [35:0] A2 = {P1[31:4], V1[23:18], 2'b00}, A3 = {P2[31:4], V1[17:12], 2'b00};
  localparam logic [35:0] B2 = {P1[31:4], V2[23:18], 2'b00};
  logic                  clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]            avs_address = 4'h0, lag = 4'h0;
  logic [31:0]           avs_writedata = 32'h0, avs_readdata, lookup_va = 32'h0, cur_va, q;
  logic                  avs_waitrequest, lookup_valid = 1'b0, lookup_instr = 1'b0, cur_ins;
  logic                  lookup_done, fetch_valid, result_valid, tlb_invalidate = 1'b0;
  logic                  req = 1'b0;
  logic [35:0]           req_addr = 36'h0;
  ptw_pkg::fetch_s       fetch, req_info = '0;
  ptw_pkg::lookup_s      lookup_result;
  ptw_pkg::walk_result_s result;
  int                    error_cnt = 0, tests_run = 0;
  logic [31:0]           td [6] = '{32'h0, 32'h3, 32'h11, 32'h82, 32'hc000_00a2, 32'hfed0_0006};
  ptw_pkg::level_e       tl [6] = '{ptw_pkg::LVL_2, ptw_pkg::LVL_1, ptw_pkg::LVL_3,
                                    ptw_pkg::LVL_3, ptw_pkg::LVL_CTX, ptw_pkg::LVL_1};
  logic [2:0]            te [6] = '{3'b100, 3'b010, 3'b010, 3'b010, 3'b001, 3'b001};

  always #5 clk = ~clk;

  ptw_helper dut_u (.*);
  table_mem_model mem_u (.*);

  ////////////////////////////////////////
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task look(input logic [31:0] va, input logic ins);
    @(posedge clk);
    lookup_valid <= 1'b1;
    lookup_va    <= va;
    lookup_instr <= ins;
    @(posedge clk);
    lookup_valid <= 1'b0;
    while (lookup_done !== 1'b1) @(posedge clk);
  endtask : look

  // One fetch through the model; lg makes the far side slow
  task step(input logic [35:0] a, input ptw_pkg::level_e lv, input logic wr, input logic be,
            input logic [3:0] lg);
    @(posedge clk);
    req      <= 1'b1;
    req_addr <= a;
    lag      <= lg;
    req_info <= '{lv, 32'h0, cur_va, cur_ins, wr, be};
    @(posedge clk);
    req <= 1'b0;
    while (result_valid !== 1'b1) @(posedge clk);
  endtask : step

  ////////////////////////////////////////
  task t_regs;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'(i * 4), 32'h0);
      `CHK(q, 32'h0)
    end
    bus(1'b1, ptw_pkg::REG_CTX_BASE, BW);
    bus(1'b1, ptw_pkg::REG_CTX_NUM, CW);
    bus(1'b1, ptw_pkg::REG_STATUS, 32'hffff_ffff);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, ptw_pkg::REG_CTX_BASE, 32'h0);
    `CHK(q, BW & 32'hffff_fc00)
    bus(1'b0, ptw_pkg::REG_CTX_NUM, 32'h0);
    `CHK(q, CW & 32'h0000_0fff)
    bus(1'b0, ptw_pkg::REG_STATUS, 32'h0);
    `CHK(q, 32'h0)
  endtask : t_regs

  task t_walk4;
    cur_va  = V1;
    cur_ins = 1'b1;
    look(V1, 1'b1);
    `CHK(({lookup_result.l2_hit, lookup_result.root_hit}), 2'b00)
    `CHK(({lookup_result.start_level, lookup_result.start_addr}), ({ptw_pkg::LVL_CTX, A0}))
    step(A0, ptw_pkg::LVL_CTX, 1'b0, 1'b0, 4'h0);
    `CHK(result.next_addr, A1)
    step(A1, ptw_pkg::LVL_1, 1'b0, 1'b0, 4'h2);
    `CHK(result.next_addr, A2)
    step(A2, ptw_pkg::LVL_2, 1'b0, 1'b0, 4'h5);
    `CHK(result.next_addr, A3)
    step(A3, ptw_pkg::LVL_3, 1'b0, 1'b0, 4'h0);
    `CHK(result.phys_addr, ({PG[31:8], V1[11:0]}))
    `CHK(({result.cacheable, result.region_log2}), ({1'b1, ptw_pkg::REGION_L3}))
    `CHK(result.writeback_entry, PG | 32'h20)
    look(V1, 1'b1);
    `CHK(({lookup_result.l2_hit, lookup_result.root_hit}), 2'b11)
    `CHK(({lookup_result.start_level, lookup_result.start_addr}), ({ptw_pkg::LVL_3, A3}))
    bus(1'b0, ptw_pkg::REG_STATUS, 32'h0);
    `CHK(({q[0], q[4:3], q[1] ^ q[2], q[5] ^ q[1]}), 5'b10010)
  endtask : t_walk4

  task t_l2page;
    cur_va  = V2;
    cur_ins = 1'b0;
    look(V2, 1'b0);
    `CHK(({lookup_result.l2_hit, lookup_result.root_hit}), 2'b01)
    `CHK(lookup_result.start_addr, A1)
    step(A1, ptw_pkg::LVL_1, 1'b0, 1'b0, 4'h1);
    `CHK(result.next_addr, B2)
    step(B2, ptw_pkg::LVL_2, 1'b1, 1'b0, 4'h0);
    `CHK(result.phys_addr, ({PG2[31:14], V2[17:0]}))
    `CHK(({result.cacheable, result.region_log2}), ({1'b0, ptw_pkg::REGION_L2}))
    `CHK(({result.writeback, result.writeback_entry}), ({1'b1, PG2 | 32'h60}))
    look(V2, 1'b0);
    `CHK(({lookup_result.l2_hit, lookup_result.root_hit}), 2'b01)
  endtask : t_l2page

  task t_inval;
    look(V1, 1'b1);
    `CHK(lookup_result.l2_hit, 1'b1)
    @(posedge clk);
    tlb_invalidate <= 1'b1;
    @(posedge clk);
    tlb_invalidate <= 1'b0;
    look(V1, 1'b1);
    `CHK(({lookup_result.l2_hit, lookup_result.root_hit}), 2'b01)
    // Rewriting the same context number still counts as a change
    bus(1'b1, ptw_pkg::REG_CTX_NUM, CW);
    look(V1, 1'b1);
    `CHK(({lookup_result.root_hit, lookup_result.start_addr}), ({1'b0, A0}))
    cur_va = V1;
    step(A0, ptw_pkg::LVL_CTX, 1'b0, 1'b0, 4'h3);
    bus(1'b0, ptw_pkg::REG_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    bus(1'b1, ptw_pkg::REG_CTX_BASE, BW);
    bus(1'b0, ptw_pkg::REG_STATUS, 32'h0);
    `CHK(q[4:0], 5'h00)
  endtask : t_inval

  task t_table;
    cur_va = 32'h89ab_cdef;
    for (int i = 0; i < 6; i++)
    begin
      mem_u.mem[36'h100 + 36'(4 * i)] = td[i];
      step(36'h100 + 36'(4 * i), tl[i], 1'b0, i == 3, 4'(i));
      `CHK(({result.fault_invalid, result.fault_translation, result.found_page}), te[i])
      if (te[i][0])
      begin
        `CHK(result.phys_addr, (tl[i] == ptw_pkg::LVL_CTX ? {td[i][31:28], cur_va} :
          {td[i][31:20], cur_va[23:0]}))
        `CHK(result.region_log2, (tl[i] == ptw_pkg::LVL_CTX ? ptw_pkg::REGION_CTX :
          ptw_pkg::REGION_L1))
      end
    end
  endtask : t_table

  task wrap_up;
    $display("Mismatches %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////
  initial
  begin
    mem_u.mem[A0] = RT;
    mem_u.mem[A1] = P1;
    mem_u.mem[A2] = P2;
    mem_u.mem[A3] = PG;
    mem_u.mem[B2] = PG2;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_walk4;
    t_l2page;
    t_inval;
    t_table;
    wrap_up;
  end

  // The whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule : page_table_pointer_cache_walk_tb
